// ---- hw/sbtp_fifo.sv ----
// Purpose: small ready/valid FIFO for read data beats
// Assumes: one clock, synchronous active-high reset
// Notes: DEPTH must be a power of two
`timescale 1ns/10ps
module sbtp_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    always_comb begin
        in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
        out_valid_o = wp_q != rp_q;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_d = wp_q + (AW+1)'(push);
        rp_d = rp_q + (AW+1)'(pop);
        out_data_o = mem_q[rp_q[AW-1:0]];
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// ---- hw/sbtp_master.sv ----
// Purpose: Level 1 bus master driving the multiplexed address/data bus
// Assumes: external arbiter, slave acknowledges on the three active-low lines
// Notes: read beats pass through a 4-word FIFO; stall on it holds off new commands, reads and writes
// Notes on behaviour
// - Address cycle then one or more data cycles
// - Sizes 1 to 128 bytes, eight per beat; the code takes 1 to 8 bytes in one beat and 32-byte line bursts only
// - Non-burst data in size/address selected lanes
// - Own bus, assert busy, one-clock strobe
// - Slave data-ready strobe per good beat
// - Decode acknowledge triple per table
// - Error may end transaction any beat
// - Retry reissues from fresh address phase
// - Relinquish: drop busy, re-arbitrate
// - Slave inserts waits by holding acks
// - Master takes one beat per clock
// - Release busy after final acknowledge
// - Read min two cycles, three with data
// - Locked back-to-back reads need dead cycle
// - Write beat after address, next after ready
// - Write min two cycles
// - Never assert snoop lines during writes
// - Relinquishing slave guards written line addresses
// - Size field is log2 of bytes
// - Larger than eight bytes needs several readies
`timescale 1ns/10ps
`include "sbtp_defines.svh"
module sbtp_master
    import sbtp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // User command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire sbtp_cmd_s cmd_i,
    input wire logic [255:0] line_wdata_i,
    // User completion
    output logic done_o,
    output logic [2:0] done_status_o,
    // Read beats
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output sbtp_beat_s rd_beat_o,
    // Arbiter
    output logic bus_req_o,
    input wire logic bus_grant_i,
    // Bus pins
    output logic bus_busy_n_o,
    output logic addr_strobe_n_o,
    input wire logic [63:0] muxed_addr_data_i,
    output logic [63:0] muxed_addr_data_o,
    output logic muxed_addr_data_oe_n_o,
    input wire logic ack_ready_n_i,
    input wire logic ack_error_n_i,
    input wire logic ack_retry_n_i,
    output logic snoop_shared_n_o,
    output logic snoop_inhibit_n_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic sbtp_ack_e decode_ack(input logic e_n, input logic r_n, input logic t_n);
        decode_ack = sbtp_ack_e'({~e_n, ~r_n, ~t_n});
    endfunction

    // Address cycle word; identity and unused fields driven high
    function automatic logic [63:0] addr_word(input sbtp_cmd_s c, input logic wr);
        addr_word = {4'hf, 1'b1, 5'h1f, 8'hff, 1'b0, c.atomic, 1'b0, c.size,
                     wr ? `SBTP_TYPE_WRITE : `SBTP_TYPE_READ, c.addr};
    endfunction

    function automatic logic [2:0] beat_count(input logic burst);
        beat_count = burst ? `SBTP_LINE_BEATS : 3'h1;
    endfunction

    // Place non-burst data in its lanes; byte 0 is the top byte
    function automatic logic [63:0] place_lanes(input logic [63:0] d, input logic [2:0] sz,
                                                input logic [2:0] a);
        logic [5:0] sh;
        sh = 6'h0;
        unique case (sz)
            3'h0: sh = {3'h7 - a, 3'h0};
            3'h1: sh = {3'h6 - {a[2:1], 1'b0}, 3'h0};
            3'h2: sh = {3'h4 - {a[2], 2'b00}, 3'h0};
            default: sh = 6'h0;
        endcase
        place_lanes = d << sh;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sbtp_state_e state_q, state_d;
    sbtp_cmd_s cmd_q, cmd_d;
    logic [255:0] line_q, line_d;
    logic [2:0] beat_q, beat_d;
    logic wr_phase_q, wr_phase_d;
    logic busy_q, busy_d;
    logic as_q, as_d;
    logic oe_q, oe_d;
    logic [63:0] mad_q, mad_d;
    logic done_q, done_d;
    logic [2:0] status_q, status_d;
    logic push_valid, push_ready;
    sbtp_beat_s push_beat;
    sbtp_ack_e ack;
    logic is_write, beats_left;

    // ------------------------------------------------------------
    // Transaction control
    // ------------------------------------------------------------
    always_comb begin
        ack = decode_ack(ack_error_n_i, ack_ready_n_i, ack_retry_n_i);
        is_write = cmd_q.write || (cmd_q.atomic && wr_phase_q);
        beats_left = beat_q != 3'h1;
        state_d = state_q;
        cmd_d = cmd_q;
        line_d = line_q;
        beat_d = beat_q;
        wr_phase_d = wr_phase_q;
        busy_d = busy_q;
        as_d = 1'b0;
        oe_d = oe_q;
        mad_d = mad_q;
        done_d = 1'b0;
        status_d = status_q;
        push_valid = 1'b0;
        push_beat.last = ~beats_left;
        push_beat.data = muxed_addr_data_i;
        unique case (state_q)
            SBTP_IDLE: begin
                if (cmd_valid_i && cmd_ready_o) begin
                    cmd_d = cmd_i;
                    // Noncacheable single beat, cacheable line burst
                    cmd_d.size = cmd_i.burst ? `SBTP_SIZE_LINE : cmd_i.size;
                    if (cmd_i.burst) begin
                        cmd_d.addr[4:0] = 5'h00;
                    end
                    line_d = line_wdata_i;
                    wr_phase_d = 1'b0;
                    state_d = SBTP_REQ;
                end
            end
            SBTP_REQ: begin
                // Grant may lag the request by a clock; wait for it
                if (bus_grant_i) begin
                    busy_d = 1'b1;
                    as_d = 1'b1;
                    oe_d = 1'b1;
                    beat_d = beat_count(cmd_q.burst);
                    mad_d = addr_word(cmd_q, is_write);
                    state_d = SBTP_ADDR;
                end
            end
            SBTP_ADDR: begin
                if (is_write) begin
                    // First write beat right after the address cycle
                    mad_d = cmd_q.burst ? line_q[255:192]
                          : place_lanes(cmd_q.wdata, cmd_q.size, cmd_q.addr[2:0]);
                end else begin
                    oe_d = 1'b0;
                end
                state_d = SBTP_DATA;
            end
            SBTP_DATA: begin
                unique case (ack)
                    SBTP_ACK_NONE: begin
                    end
                    SBTP_ACK_DATA: begin
                        if (!is_write) begin
                            push_valid = 1'b1;
                        end
                        beat_d = beat_q - 3'h1;
                        if (is_write) begin
                            line_d = {line_q[191:0], 64'h0};
                            mad_d = line_q[191:128];
                        end
                        if (!beats_left) begin
                            if (cmd_q.atomic && !wr_phase_q) begin
                                // Read part done; the dead cycle keeps the bus quiet
                                // before the write address, busy held
                                wr_phase_d = 1'b1;
                                state_d = SBTP_DEAD;
                            end else begin
                                busy_d = 1'b0;
                                oe_d = 1'b0;
                                done_d = 1'b1;
                                status_d = SBTP_ACK_DATA;
                                // Nonzero count tells the dead cycle the work is over
                                beat_d = 3'h1;
                                state_d = is_write ? SBTP_IDLE : SBTP_DEAD;
                            end
                        end
                    end
                    SBTP_ACK_RETRY: begin
                        // Bus released for the dead cycle; busy stays held
                        oe_d = 1'b0;
                        state_d = SBTP_DEAD;
                        beat_d = 3'h0;
                    end
                    SBTP_ACK_RR: begin
                        busy_d = 1'b0;
                        oe_d = 1'b0;
                        beat_d = 3'h0;
                        // Atomic keeps wr_phase: read part redone only if unfinished
                        state_d = SBTP_DEAD;
                    end
                    default: begin
                        busy_d = 1'b0;
                        oe_d = 1'b0;
                        done_d = 1'b1;
                        status_d = ack;
                        state_d = SBTP_DEAD;
                    end
                endcase
            end
            SBTP_DEAD: begin
                // Idle clock; then finish, reissue with busy held, or re-arbitrate
                if (beat_q != 3'h0) begin
                    state_d = SBTP_IDLE;
                end else if (busy_q) begin
                    as_d = 1'b1;
                    oe_d = 1'b1;
                    beat_d = beat_count(cmd_q.burst);
                    mad_d = addr_word(cmd_q, is_write);
                    state_d = SBTP_ADDR;
                end else begin
                    state_d = SBTP_REQ;
                end
            end
            default: state_d = SBTP_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= SBTP_IDLE;
            cmd_q <= '0;
            line_q <= '0;
            beat_q <= 3'h0;
            wr_phase_q <= 1'b0;
            busy_q <= 1'b0;
            as_q <= 1'b0;
            oe_q <= 1'b0;
            mad_q <= 64'h0;
            done_q <= 1'b0;
            status_q <= 3'h0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            line_q <= line_d;
            beat_q <= beat_d;
            wr_phase_q <= wr_phase_d;
            busy_q <= busy_d;
            as_q <= as_d;
            oe_q <= oe_d;
            mad_q <= mad_d;
            done_q <= done_d;
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // Read buffer
    // ------------------------------------------------------------
    // Ready is not checked per beat: a new command of either type waits for an empty buffer
    sbtp_fifo #(.WIDTH(65), .DEPTH(`SBTP_FIFO_DEPTH)) u_rd_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_beat),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_beat_o)
    );

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    assign cmd_ready_o = (state_q == SBTP_IDLE) && push_ready && !rd_valid_o;
    assign bus_req_o = state_q == SBTP_REQ;
    assign bus_busy_n_o = ~busy_q;
    assign addr_strobe_n_o = ~as_q;
    assign muxed_addr_data_o = mad_q;
    assign muxed_addr_data_oe_n_o = ~oe_q;
    assign snoop_shared_n_o = 1'b1;
    assign snoop_inhibit_n_o = 1'b1;
    assign done_o = done_q;
    assign done_status_o = status_q;
endmodule

// ---- inc/sbtp_defines.svh ----
// Purpose: constants for the bus master (address cycle fields, sizes, line beats, FIFO depth)
// Assumes: 64-bit multiplexed address/data bus, single bus clock
// Notes: address cycle field positions and type/size codes live here; ack codes are in sbtp_pkg
`ifndef SBTP_DEFINES_SVH
`define SBTP_DEFINES_SVH

`define SBTP_DATA_W 64
`define SBTP_ADDR_W 36
`define SBTP_SIZE_LSB 40
`define SBTP_SIZE_MSB 42
`define SBTP_TYPE_LSB 36
`define SBTP_TYPE_MSB 39
`define SBTP_TYPE_READ 4'h1
`define SBTP_TYPE_WRITE 4'h0
`define SBTP_SIZE_LINE 3'h5
`define SBTP_SIZE_DWORD 3'h3
`define SBTP_LINE_BEATS 3'h4
`define SBTP_HIGH_FIELD 19'h7ffff
`define SBTP_FIFO_DEPTH 4

`endif

// ---- inc/sbtp_pkg.sv ----
// Purpose: types shared by the bus master and its testbench
// Assumes: sbtp_defines.svh is on the include path
// Notes: none
package sbtp_pkg;
    typedef enum logic [2:0] {
        SBTP_IDLE = 3'b000,
        SBTP_REQ = 3'b001,
        SBTP_ADDR = 3'b010,
        SBTP_DATA = 3'b011,
        SBTP_DEAD = 3'b100
    } sbtp_state_e;

    typedef enum logic [2:0] {
        SBTP_ACK_NONE = 3'b000,
        SBTP_ACK_RR = 3'b001,
        SBTP_ACK_DATA = 3'b010,
        SBTP_ACK_RSVD = 3'b011,
        SBTP_ACK_BERR = 3'b100,
        SBTP_ACK_TOUT = 3'b101,
        SBTP_ACK_UERR = 3'b110,
        SBTP_ACK_RETRY = 3'b111
    } sbtp_ack_e;

    typedef struct packed {
        logic write;
        logic atomic;
        logic burst;
        logic [2:0] size;
        logic [35:0] addr;
        logic [63:0] wdata;
    } sbtp_cmd_s;

    typedef struct packed {
        logic last;
        logic [63:0] data;
    } sbtp_beat_s;
endpackage

// ---- testbench/sbtp_master_monitor.sv ----
// Purpose: pin-level protocol checks on the bus master
// Assumes: the slave acknowledges only inside the data phase
// Notes: code is the acknowledge triple inverted, as in sbtp_ack_e
`timescale 1ns/10ps
module sbtp_mon
    import sbtp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Bus side
    input wire logic bus_grant_i,
    input wire logic bus_busy_n_o,
    input wire logic addr_strobe_n_o,
    input wire logic [63:0] muxed_addr_data_o,
    input wire logic muxed_addr_data_oe_n_o,
    input wire logic ack_ready_n_i,
    input wire logic ack_error_n_i,
    input wire logic ack_retry_n_i,
    input wire logic snoop_shared_n_o,
    input wire logic snoop_inhibit_n_o,
    // Completion
    input wire logic done_o,
    input wire logic [2:0] done_status_o
);
    logic [2:0] code;
    logic [63:0] muxed_addr_data;
    logic rd_q;
    assign code = ~{ack_error_n_i, ack_ready_n_i, ack_retry_n_i};
    assign muxed_addr_data = muxed_addr_data_o;
    // Remember the type of the transaction in flight
    always_ff @(posedge core_clk_i) begin
        if (rst_i) rd_q <= 1'b0;
        else if (!addr_strobe_n_o) rd_q <= (muxed_addr_data[39:36] == 4'h1);
    end
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // ----
    // Assertions
    // ----
    strobe_pulse_a: assert property ($fell(addr_strobe_n_o) |=> addr_strobe_n_o)
        else $error("address strobe longer than one clock");
    strobe_busy_a: assert property (!addr_strobe_n_o |-> !bus_busy_n_o)
        else $error("address strobe without bus busy");
    busy_owned_a: assert property ($fell(bus_busy_n_o) |-> $past(bus_grant_i))
        else $error("bus busy taken without grant");
    no_snoop_a: assert property (snoop_shared_n_o && snoop_inhibit_n_o)
        else $error("snoop line asserted");
    burst_line_a: assert property (!addr_strobe_n_o && muxed_addr_data[42:40] > 3'h3 |->
        muxed_addr_data[42:40] == 3'h5 && muxed_addr_data[4:0] == 5'h0)
        else $error("burst not an aligned line");
    read_gap_a: assert property (!bus_busy_n_o && rd_q && code != 3'h0 |=> addr_strobe_n_o)
        else $error("no idle clock after read");
    write_gap_a: assert property (!bus_busy_n_o && !rd_q && code != 3'h0
        && code != SBTP_ACK_DATA |=> addr_strobe_n_o)
        else $error("no idle clock after failed write");
    write_beat_a: assert property (!addr_strobe_n_o && muxed_addr_data[39:36] == 4'h0
        |=> !muxed_addr_data_oe_n_o)
        else $error("write data not driven after address");
    relinquish_a: assert property (!bus_busy_n_o && code == SBTP_ACK_RR |=> bus_busy_n_o)
        else $error("busy kept after relinquish");
    retry_again_a: assert property (!bus_busy_n_o && code == SBTP_ACK_RETRY |=>
        !bus_busy_n_o ##[1:3] !addr_strobe_n_o)
        else $error("retry not reissued");
    error_end_a: assert property (!bus_busy_n_o && code inside {3'h4, 3'h5, 3'h6} |=>
        bus_busy_n_o && done_o && done_status_o == $past(code))
        else $error("error did not end transaction");
    burst_seen_c: cover property (!addr_strobe_n_o && muxed_addr_data[42:40] == 3'h5);
    retry_seen_c: cover property (code == SBTP_ACK_RETRY);
    rr_seen_c: cover property (code == SBTP_ACK_RR);
endmodule

bind sbtp_master sbtp_mon mon (.core_clk_i, .rst_i, .bus_grant_i, .bus_busy_n_o,
    .addr_strobe_n_o, .muxed_addr_data_o, .muxed_addr_data_oe_n_o, .ack_ready_n_i,
    .ack_error_n_i, .ack_retry_n_i, .snoop_shared_n_o, .snoop_inhibit_n_o, .done_o,
    .done_status_o);

// ---- testbench/sbtp_master_tb_top.sv ----
// Purpose: directed scenarios for the bus master
// Assumes: inputs change at the falling edge
// Notes: expected beats follow the slave model's pattern
`timescale 1ns/10ps
`define SBTP_CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH %0t %s", $time, m); end end
module sbtp_master_tb_top
    import sbtp_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic rd_ready_i = 1'b0;
    sbtp_cmd_s cmd_i = '0;
    logic [255:0] line_wdata_i = '0;
    logic cmd_ready_o, done_o, rd_valid_o, bus_req_o, bus_grant_i, bus_busy_n_o;
    logic addr_strobe_n_o, oe_n, ack_ready_n_i, ack_error_n_i, ack_retry_n_i;
    logic [2:0] done_status_o;
    sbtp_beat_s rd_beat_o;
    logic [63:0] mad_o, mad_i;
    int n_errors = 0, n_compared = 0, cyc = 0;
    sbtp_master dut (.core_clk_i, .rst_i, .cmd_valid_i, .cmd_ready_o, .cmd_i, .line_wdata_i,
        .done_o, .done_status_o, .rd_valid_o, .rd_ready_i, .rd_beat_o, .bus_req_o,
        .bus_grant_i, .bus_busy_n_o, .addr_strobe_n_o, .muxed_addr_data_i(mad_i),
        .muxed_addr_data_o(mad_o), .muxed_addr_data_oe_n_o(oe_n), .ack_ready_n_i,
        .ack_error_n_i, .ack_retry_n_i, .snoop_shared_n_o(), .snoop_inhibit_n_o());
    sbtp_slave_model slv (.core_clk_i, .rst_i, .bus_req_i(bus_req_o),
        .bus_grant_o(bus_grant_i), .addr_strobe_n_i(addr_strobe_n_o), .mad_out_i(mad_o),
        .mad_oe_n_i(oe_n), .mad_bus_o(mad_i), .ack_ready_n_o(ack_ready_n_i),
        .ack_error_n_o(ack_error_n_i), .ack_retry_n_o(ack_retry_n_i));
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    // ----
    // Shared tasks
    // ----
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic run(input logic w, a, b, input logic [2:0] s, input logic [35:0] ad,
                       input logic [63:0] wd, input logic [2:0] st);
        int t;
        @(negedge core_clk_i);
        cmd_i = '{w, a, b, s, ad, wd};
        cmd_valid_i = 1'b1;
        t = 0;
        while (cmd_ready_o !== 1'b1 && t < 100) begin
            @(negedge core_clk_i);
            t++;
        end
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
        t = 0;
        while (done_o !== 1'b1 && t < 300) begin
            @(negedge core_clk_i);
            t++;
        end
        `SBTP_CHK(done_o, 1'b1, "completion pulse")
        `SBTP_CHK(done_status_o, st, "completion code")
    endtask
    task automatic drain(input logic [35:0] ad, input int n);
        for (int k = 0; k < n; k++) begin
            `SBTP_CHK(rd_valid_o, 1'b1, "beat waiting")
            `SBTP_CHK(rd_beat_o, {k == n - 1, ad[31:0], 32'(k)}, "read beat")
            rd_ready_i = 1'b1;
            @(negedge core_clk_i);
        end
        rd_ready_i = 1'b0;
        `SBTP_CHK(rd_valid_o, 1'b0, "buffer empty")
    endtask
    task automatic flush();
        rd_ready_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        rd_ready_i = 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_write_lanes();
        logic [63:0] m;
        int nb, a;
        for (int s = 0; s < 4; s++) begin
            nb = 1 << s;
            a = (s == 3) ? 0 : nb;
            m = (s == 3) ? '1 : (64'h1 << (8 * nb)) - 64'h1;
            run(1'b1, 1'b0, 1'b0, 3'(s), 36'(a), 64'h1122334455667788, SBTP_ACK_DATA);
            `SBTP_CHK((slv.wcap[0] >> (64 - 8 * (a + nb))) & m, 64'h1122334455667788 & m, "lane")
            `SBTP_CHK({slv.cap_ty, slv.cap_sz, slv.cap_a}, {4'h0, 3'(s), 36'(a)}, "addr")
        end
    endtask
    task automatic t_burst_read();
        int a0, s0;
        a0 = slv.n_ack;
        run(1'b0, 1'b0, 1'b1, 3'h5, 36'h123456780, 64'h0, SBTP_ACK_DATA);
        // A second command must wait while the line sits in the buffer
        s0 = slv.n_str;
        cmd_valid_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        `SBTP_CHK(cmd_ready_o, 1'b0, "taken while buffer full")
        cmd_valid_i = 1'b0;
        `SBTP_CHK(slv.n_ack - a0, 4, "beat count")
        `SBTP_CHK(slv.n_str - s0, 0, "issued while buffer full")
        drain(36'h123456780, 4);
    endtask
    task automatic t_wait_read();
        slv.waits = 3;
        run(1'b0, 1'b0, 1'b0, 3'h3, 36'h48, 64'h0, SBTP_ACK_DATA);
        slv.waits = 0;
        drain(36'h48, 1);
    endtask
    task automatic t_errors();
        logic [2:0] codes [3] = '{SBTP_ACK_BERR, SBTP_ACK_TOUT, SBTP_ACK_UERR};
        foreach (codes[i]) begin
            slv.bad_at = slv.n_ack + 1;
            slv.bad_code = codes[i];
            run(1'b0, 1'b0, 1'b1, 3'h5, 36'h200, 64'h0, codes[i]);
            flush();
        end
    endtask
    task automatic t_retry();
        int s0;
        s0 = slv.n_str;
        slv.bad_at = slv.n_ack;
        slv.bad_code = SBTP_ACK_RETRY;
        run(1'b0, 1'b0, 1'b0, 3'h3, 36'h10, 64'h0, SBTP_ACK_DATA);
        `SBTP_CHK(slv.n_str - s0, 2, "retry reissue")
        drain(36'h10, 1);
    endtask
    task automatic t_atomic();
        int s0, r0;
        for (int p = 0; p < 2; p++) begin
            s0 = slv.n_str;
            r0 = slv.n_rd;
            slv.bad_at = slv.n_ack + p;
            slv.bad_code = SBTP_ACK_RR;
            run(1'b0, 1'b1, 1'b0, 3'h3, 36'h80, 64'h5, SBTP_ACK_DATA);
            `SBTP_CHK(slv.n_str - s0, 3, "atomic addresses")
            `SBTP_CHK(slv.n_rd - r0, 2 - p, "atomic read parts")
            flush();
        end
    endtask
    task automatic t_burst_write();
        line_wdata_i = 256'h0011223344556677_8899aabbccddeeff_0f1e2d3c4b5a6978_8796a5b4c3d2e1f0;
        slv.waits = 2;
        run(1'b1, 1'b0, 1'b1, 3'h5, 36'h400, 64'h0, SBTP_ACK_DATA);
        slv.waits = 0;
        for (int k = 0; k < 4; k++) begin
            `SBTP_CHK(slv.wcap[k], line_wdata_i[255 - 64 * k -: 64], "write beat")
        end
    endtask
    // ----
    // Main sequence and watchdog
    // ----
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk_i);
        rst_i = 1'b0;
        t_write_lanes();
        t_burst_read();
        t_wait_read();
        t_errors();
        t_retry();
        t_atomic();
        t_burst_write();
        finish_test();
    end
endmodule

// ---- testbench/sbtp_slave_model.sv ----
// Purpose: memory slave and arbiter facing the bus master
// Assumes: knobs and counters are set and read by the bench
// Notes: undriven wire shows a pattern that flips every clock
`timescale 1ns/10ps
module sbtp_slave_model
    import sbtp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Arbiter
    input wire logic bus_req_i,
    output logic bus_grant_o,
    // Bus pins
    input wire logic addr_strobe_n_i,
    input wire logic [63:0] mad_out_i,
    input wire logic mad_oe_n_i,
    output logic [63:0] mad_bus_o,
    output logic ack_ready_n_o,
    output logic ack_error_n_o,
    output logic ack_retry_n_o
);
    int waits = 0, bad_at = -1, n_ack = 0, n_str = 0, n_rd = 0;
    int cnt = 0, beats = 0, k = 0, kw = 0;
    logic [2:0] bad_code = SBTP_ACK_NONE;
    logic [2:0] code = SBTP_ACK_NONE;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic [63:0] rdat = 64'h0;
    logic [35:0] cap_a;
    logic [2:0] cap_sz;
    logic [3:0] cap_ty;
    logic [63:0] wcap [4];
    assign mad_bus_o = mad_oe_n_i ? rdat : mad_out_i;
    assign {ack_error_n_o, ack_ready_n_o, ack_retry_n_o} = ~code;
    always @(posedge core_clk_i) begin
        if (code == SBTP_ACK_DATA && !rd && kw < 4) begin
            wcap[kw] <= mad_bus_o;
            kw++;
        end
        bus_grant_o <= bus_req_i && !rst_i;
        code <= SBTP_ACK_NONE;
        rdat <= ~rdat;
        if (rst_i) begin
            act <= 1'b0;
        end else if (!addr_strobe_n_i) begin
            rd = (mad_out_i[39:36] == 4'h1);
            cap_a <= mad_out_i[35:0];
            cap_sz <= mad_out_i[42:40];
            cap_ty <= mad_out_i[39:36];
            n_str++;
            if (rd) n_rd++;
            beats = (mad_out_i[42:40] > 3'h3) ? (1 << (mad_out_i[42:40] - 3'h3)) : 1;
            cnt = waits;
            k = 0;
            kw = 0;
            act <= 1'b1;
        end else if (act && cnt > 0) begin
            cnt--;
        end else if (act) begin
            if (n_ack == bad_at) begin
                code <= bad_code;
                act <= 1'b0;
            end else begin
                code <= SBTP_ACK_DATA;
                rdat <= {cap_a[31:0], 32'(k)};
                k++;
                act <= (k < beats);
            end
            n_ack++;
        end
    end
endmodule
